// [hdl/dual_adc_conversion_control.sv]
`timescale 1ns/1ps
module dual_adc_conversion_control
	import conv_ctrl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic master_clock,
	input wire logic convert_start,
	input wire logic read_sync,
	input wire logic channel_count_select,
	input wire logic output_port_select,
	input wire logic pair_address_select,
	input wire logic [CODE_BITS-1:0] code_a,
	input wire logic [CODE_BITS-1:0] code_b,
	output logic hold_a,
	output logic hold_b,
	output logic input_select,
	output logic busy,
	output logic serial_a,
	output logic serial_b,
	output logic serial_b_oe,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata
);
	// Pin synchronisers: stage one feeds stage two only
	logic [PIN_COUNT-1:0] meta_q, sync_q, pin_bank;
	logic mclk_prev_q, start_prev_q, rsync_prev_q;
	assign pin_bank = {pair_address_select, output_port_select, channel_count_select, read_sync,
		convert_start, master_clock};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end
				else
				begin
					meta_q[gi] <= pin_bank[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mclk_prev_q <= 1'b0;
			start_prev_q <= 1'b0;
			rsync_prev_q <= 1'b0;
		end
		else
		begin
			mclk_prev_q <= sync_q[PIN_MCLK];
			start_prev_q <= sync_q[PIN_START];
			rsync_prev_q <= sync_q[PIN_RSYNC];
		end
	end

	logic m_rise, m_fall, start_rise, rsync_fall, four_ch, a_only;
	assign m_rise = sync_q[PIN_MCLK] && !mclk_prev_q;
	assign m_fall = !sync_q[PIN_MCLK] && mclk_prev_q;
	assign start_rise = sync_q[PIN_START] && !start_prev_q;
	assign rsync_fall = !sync_q[PIN_RSYNC] && rsync_prev_q;
	assign four_ch = sync_q[PIN_CHCNT];
	assign a_only = sync_q[PIN_PORT];

	// Software-set conversion length; never shorter than the minimum
	logic [5:0] conv_len_q, conv_len_d, conv_len_eff;
	assign conv_len_eff = (conv_len_q < CONV_CYCLES) ? CONV_CYCLES : conv_len_q;

	// Conversion sequencer
	conv_state_t state_q, state_d;
	logic [5:0] cnt_q, cnt_d;
	logic hold_q, hold_d, busy_q, busy_d, chan_q, chan_d, addr_q, addr_d;
	logic skip_q, skip_d, conv_done, start_ok;
	logic [CODE_BITS-1:0] res_a_q, res_a_d, res_b_q, res_b_d;
	logic buf_in_ready, buf_out_valid, buf_pop;
	logic [WORD_BITS-1:0] buf_in_data, buf_out_data;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		hold_d = hold_q;
		busy_d = busy_q;
		chan_d = chan_q;
		addr_d = addr_q;
		skip_d = skip_q;
		res_a_d = res_a_q;
		res_b_d = res_b_q;
		conv_done = 1'b0;
		start_ok = 1'b0;
		unique case (state_q)
			ST_IDLE:
			begin
				// A full buffer refuses new conversions so no result is dropped
				// A swallowed start needs no buffer room, so it is consumed even when full
				if (start_rise && a_only && skip_q)
					skip_d = 1'b0;
				else if (start_rise && buf_in_ready)
				begin
					start_ok = 1'b1;
					skip_d = a_only;
					hold_d = 1'b1;
					busy_d = 1'b1;
					cnt_d = '0;
					state_d = ST_ADDR;
				end
			end
			ST_ADDR:
			begin
				if (m_rise)
					cnt_d = cnt_q + 6'h01;
				else if (m_fall && cnt_q != '0)
				begin
					if (!four_ch)
						addr_d = sync_q[PIN_ADDR];
					state_d = ST_CONV;
				end
			end
			ST_CONV:
			begin
				if (m_rise)
				begin
					cnt_d = cnt_q + 6'h01;
					if (cnt_d == BUSY_CLEAR_CYCLE)
						busy_d = 1'b0;
					if (cnt_d == conv_len_eff)
					begin
						conv_done = 1'b1;
						hold_d = 1'b0;
						busy_d = 1'b0;
						res_a_d = code_a;
						res_b_d = code_b;
						chan_d = four_ch ? !chan_q : addr_q;
						state_d = ST_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			hold_q <= 1'b0;
			busy_q <= 1'b0;
			chan_q <= 1'b0;
			addr_q <= 1'b0;
			skip_q <= 1'b0;
			res_a_q <= '0;
			res_b_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			hold_q <= hold_d;
			busy_q <= busy_d;
			chan_q <= chan_d;
			addr_q <= addr_d;
			skip_q <= skip_d;
			res_a_q <= res_a_d;
			res_b_q <= res_b_d;
		end
	end

	// One sampler control for both pairs keeps their aperture identical
	assign hold_a = hold_q;
	assign hold_b = hold_q;
	assign input_select = chan_q;
	assign busy = busy_q;

	// Word: output mode, frame A, frame B; codes pass untouched
	assign buf_in_data = {a_only, chan_q, PAIR_A, code_a, 2'b00, chan_q, PAIR_B, code_b, 2'b00};

	pair_buffer #(
		.WIDTH(WORD_BITS),
		.DEPTH(2)
	) u_buf (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_valid(conv_done),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop),
		.out_data(buf_out_data)
	);

	// Serialiser: starts on the trailing edge of read sync
	logic [2*FRAME_BITS-1:0] sh_a_q, sh_a_d;
	logic [FRAME_BITS-1:0] sh_b_q, sh_b_d;
	logic [5:0] bits_q, bits_d;
	logic b_oe_q, b_oe_d;
	logic word_a_only;
	assign word_a_only = buf_out_data[WORD_BITS-1];

	always_comb
	begin
		sh_a_d = sh_a_q;
		sh_b_d = sh_b_q;
		bits_d = bits_q;
		b_oe_d = b_oe_q;
		buf_pop = 1'b0;
		if (rsync_fall && bits_q == '0 && buf_out_valid)
		begin
			buf_pop = 1'b1;
			b_oe_d = !word_a_only;
			sh_b_d = buf_out_data[FRAME_BITS-1:0];
			if (word_a_only)
			begin
				sh_a_d = buf_out_data[2*FRAME_BITS-1:0];
				bits_d = FRAME_BITS_SINGLE;
			end
			else
			begin
				sh_a_d = {buf_out_data[2*FRAME_BITS-1:FRAME_BITS], {FRAME_BITS{1'b0}}};
				bits_d = FRAME_BITS_DUAL;
			end
		end
		else if (m_rise && bits_q != '0)
		begin
			sh_a_d = {sh_a_q[2*FRAME_BITS-2:0], 1'b0};
			sh_b_d = {sh_b_q[FRAME_BITS-2:0], 1'b0};
			bits_d = bits_q - 6'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sh_a_q <= '0;
			sh_b_q <= '0;
			bits_q <= '0;
			b_oe_q <= 1'b1;
		end
		else
		begin
			sh_a_q <= sh_a_d;
			sh_b_q <= sh_b_d;
			bits_q <= bits_d;
			b_oe_q <= b_oe_d;
		end
	end

	assign serial_a = sh_a_q[2*FRAME_BITS-1];
	assign serial_b = sh_b_q[FRAME_BITS-1];
	assign serial_b_oe = b_oe_q;

	// Register port: read data stand only in the cycle after the strobe
	logic [31:0] rdata_q, rdata_d;

	function automatic logic [31:0] sext_code(input logic [CODE_BITS-1:0] c);
		sext_code = {{(32 - CODE_BITS){c[CODE_BITS-1]}}, c};
	endfunction : sext_code

	always_comb
	begin
		conv_len_d = conv_len_q;
		rdata_d = '0;
		if (reg_write && reg_addr == ADDR_CONV_LEN)
			conv_len_d = reg_wdata[5:0];
		if (reg_read)
		begin
			unique case (reg_addr)
				ADDR_STATUS:
				begin
					rdata_d[STAT_BUSY] = busy_q;
					rdata_d[STAT_CHAN] = chan_q;
					rdata_d[STAT_SKIP] = skip_q;
					rdata_d[STAT_FULL] = !buf_in_ready;
					rdata_d[STAT_SHIFT] = bits_q != '0;
				end
				ADDR_RESULT_A: rdata_d = sext_code(res_a_q);
				ADDR_RESULT_B: rdata_d = sext_code(res_b_q);
				ADDR_CONV_LEN: rdata_d = {26'h0000000, conv_len_q};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			conv_len_q <= CONV_LEN_RESET;
			rdata_q <= '0;
		end
		else
		begin
			conv_len_q <= conv_len_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// Checks
	AST_CONV_MIN: assert property (@(posedge ref_clk) disable iff (!resetn)
		conv_done |-> cnt_d >= CONV_CYCLES)
		else $error("conversion ended early");
	AST_START_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		start_ok |=> hold_a && hold_b && busy && state_q == ST_ADDR)
		else $error("start did not hold both samplers");
	AST_SAME_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		hold_a == hold_b)
		else $error("samplers out of step");
	AST_TWO_CH_ADDR: assert property (@(posedge ref_clk) disable iff (!resetn)
		(conv_done && !four_ch) |=> input_select == $past(addr_q))
		else $error("two-channel address not applied");
	AST_FOUR_CH_TOGGLE: assert property (@(posedge ref_clk) disable iff (!resetn)
		(conv_done && four_ch) |=> input_select != $past(input_select))
		else $error("four-channel input did not alternate");
	AST_ADDR_LATCH: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_q == ST_ADDR && m_fall && cnt_q != '0 && !four_ch)
		|=> addr_q == $past(sync_q[PIN_ADDR]) && state_q == ST_CONV)
		else $error("address not latched on first falling edge");
	AST_B_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		(buf_pop && word_a_only) |=> !serial_b_oe && bits_q == FRAME_BITS_SINGLE)
		else $error("output B still driven in single-port mode");
	AST_FRAME_HEAD: assert property (@(posedge ref_clk) disable iff (!resetn)
		(buf_pop && !word_a_only)
		|=> serial_a == $past(buf_out_data[2*FRAME_BITS-1]) && bits_q == FRAME_BITS_DUAL)
		else $error("frame did not open with channel flag");
	AST_SKIP_START: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_q == ST_IDLE && start_rise && a_only && skip_q)
		|=> state_q == ST_IDLE && !skip_q)
		else $error("second start in single-port mode not ignored");
	AST_BUSY_CLEAR: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_q == ST_CONV && m_rise && cnt_q == BUSY_CLEAR_CYCLE - 6'h01) |=> !busy)
		else $error("busy not cleared after third LSB");

endmodule : dual_adc_conversion_control

// [hdl/conv_ctrl_pkg.sv]
package conv_ctrl_pkg;

	// Conversion timing, in cycles of the external master clock
	localparam logic [5:0] CONV_CYCLES = 6'h10;
	localparam logic [5:0] BUSY_CLEAR_CYCLE = 6'h0c;
	localparam logic [5:0] FRAME_BITS_DUAL = 6'h10;
	localparam logic [5:0] FRAME_BITS_SINGLE = 6'h20;

	localparam int CODE_BITS = 12;
	localparam int FRAME_BITS = 16;
	localparam int WORD_BITS = 2 * FRAME_BITS + 1;

	// Pair flag carried in the second frame bit
	localparam logic PAIR_A = 1'b0;
	localparam logic PAIR_B = 1'b1;

	// Register map (byte addresses)
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_RESULT_A = 4'h4;
	localparam logic [3:0] ADDR_RESULT_B = 4'h8;
	localparam logic [3:0] ADDR_CONV_LEN = 4'hc;

	localparam logic [5:0] CONV_LEN_RESET = 6'h10;

	// Status field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_CHAN = 1;
	localparam int STAT_SKIP = 2;
	localparam int STAT_FULL = 3;
	localparam int STAT_SHIFT = 4;

	// Index of each pin in the synchroniser bank
	localparam int PIN_MCLK = 0;
	localparam int PIN_START = 1;
	localparam int PIN_RSYNC = 2;
	localparam int PIN_CHCNT = 3;
	localparam int PIN_PORT = 4;
	localparam int PIN_ADDR = 5;
	localparam int PIN_COUNT = 6;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_CONV = 2'b11
	} conv_state_t;

endpackage : conv_ctrl_pkg

// [hdl/pair_buffer.sv]
`timescale 1ns/1ps
module pair_buffer
	import conv_ctrl_pkg::*;
#(
	parameter int WIDTH = 33,
	parameter int DEPTH = 2
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [AW:0] count_q, count_d;
	logic push, pop;

	assign in_ready = count_q != DEPTH_CNT;
	assign out_valid = count_q != '0;
	assign out_data = mem[rd_ptr_q];

	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (push)
			wr_ptr_d = (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
		if (pop)
			rd_ptr_d = (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
		if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end

	// Storage needs no reset; only words counted as held are ever read
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

endmodule : pair_buffer

// [verification/host_clock_model.sv]
`timescale 1ns/1ps
module host_clock_model
#(
	parameter int HALF = 6
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	output logic master_clock
);
	// Twelve system cycles a period, close to the 8 MHz rate.
	// Free running, because the conversion itself needs the clock.
	int cnt;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 0;
			master_clock <= 1'b0;
		end
		else if (cnt == HALF - 1)
		begin
			cnt <= 0;
			master_clock <= ~master_clock;
		end
		else
		begin
			cnt <= cnt + 1;
		end
	end
endmodule : host_clock_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb
	import conv_ctrl_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn, master_clock, convert_start, read_sync;
	logic channel_count_select, output_port_select, pair_address_select;
	logic [11:0] code_a, code_b;
	logic hold_a, hold_b, input_select, busy, serial_a, serial_b, serial_b_oe;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic reg_write, reg_read, prev_sel;
	int error_cnt, tests_run, hold_cnt, busy_cnt;

	always #5 ref_clk = ~ref_clk;

	host_clock_model host (.ref_clk(ref_clk), .resetn(resetn), .master_clock(master_clock));

	dual_adc_conversion_control DUT (.ref_clk(ref_clk), .resetn(resetn),
		.master_clock(master_clock), .convert_start(convert_start), .read_sync(read_sync),
		.channel_count_select(channel_count_select), .output_port_select(output_port_select),
		.pair_address_select(pair_address_select), .code_a(code_a), .code_b(code_b),
		.hold_a(hold_a), .hold_b(hold_b), .input_select(input_select), .busy(busy),
		.serial_a(serial_a), .serial_b(serial_b), .serial_b_oe(serial_b_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata));

	// Host strobes follow a master rise, so these counts never straddle a pin edge
	always @(posedge master_clock)
	begin
		if (hold_a === 1'b1)
			hold_cnt++;
		if (busy === 1'b1)
			busy_cnt++;
	end

	task automatic give_verdict();
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask : check

	function automatic logic [15:0] frm(input logic ch, input logic pair, input logic [11:0] c);
		return {ch, pair, c, 2'b00};
	endfunction : frm

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask : reg_rd

	task automatic convert(input bit run, input int len);
		@(posedge master_clock);
		@(posedge ref_clk);
		hold_cnt = 0;
		busy_cnt = 0;
		convert_start <= 1'b1;
		repeat (8) @(posedge ref_clk);
		convert_start <= 1'b0;
		check("hold_a", run, hold_a);
		check("hold_b", run, hold_b);
		check("busy", run, busy);
		if (run)
		begin
			for (int i = 0; i < 1000 && hold_a !== 1'b0; i++)
				@(posedge ref_clk);
			check("hold length", len, hold_cnt);
			check("busy length", 12, busy_cnt);
		end
	endtask : convert

	task automatic read_frames(input int n, input logic [31:0] ea, eb, input logic oe,
		input bit tie);
		logic [31:0] ga, gb;
		ga = '0;
		gb = '0;
		@(posedge master_clock);
		@(posedge ref_clk);
		if (tie)
		begin
			// Both pins joined: one strobe starts a conversion and its trailing edge reads
			convert_start <= 1'b1;
			read_sync <= 1'b1;
			repeat (5) @(posedge ref_clk);
			convert_start <= 1'b0;
		end
		read_sync <= 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge master_clock);
			ga[i] = serial_a;
			gb[i] = serial_b;
		end
		check("serial_b_oe", oe, serial_b_oe);
		@(posedge ref_clk);
		read_sync <= !tie;
		check("serial_a", ea, ga);
		if (oe)
			check("serial_b", eb, gb);
	endtask : read_frames

	initial
	begin
		#300000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		error_cnt = 0;
		tests_run = 0;
		resetn = 1'b0;
		convert_start = 1'b0;
		read_sync = 1'b1;
		channel_count_select = 1'b0;
		output_port_select = 1'b1;
		pair_address_select = 1'b0;
		code_a = 12'h7ff;
		code_b = 12'h800;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		check("serial_b_oe reset", 1, serial_b_oe);
		reg_rd(ADDR_STATUS, rd);
		check("status", 0, rd);
		reg_rd(ADDR_CONV_LEN, rd);
		check("conv_len", {26'h0, CONV_LEN_RESET}, rd);
		reg_rd(4'h2, rd);
		check("unmapped", 0, rd);
		// Output A alone: both frames on one line, next start swallowed
		convert(1, 16);
		reg_rd(ADDR_STATUS, rd);
		check("skip pending", 1, rd[STAT_SKIP]);
		read_frames(32, {frm(0, PAIR_A, 12'h7ff), frm(0, PAIR_B, 12'h800)}, 0, 0, 0);
		convert(0, 16);
		// Mode pins move only between transfers
		output_port_select <= 1'b0;
		pair_address_select <= 1'b1;
		code_a <= 12'h000;
		code_b <= 12'hfff;
		convert(1, 16);
		check("input_select", 1, input_select);
		code_a <= 12'h801;
		code_b <= 12'h7fe;
		convert(1, 16);
		// Nobody reads, so the two-entry buffer fills and refuses a third start
		reg_rd(ADDR_STATUS, rd);
		check("buffer full", 1, rd[STAT_FULL]);
		convert(0, 16);
		reg_rd(ADDR_RESULT_A, rd);
		check("result_a", 32'hfffff801, rd);
		reg_rd(ADDR_RESULT_B, rd);
		check("result_b", 32'h7fe, rd);
		read_frames(16, frm(0, PAIR_A, 12'h000), frm(0, PAIR_B, 12'hfff), 1, 0);
		read_frames(16, frm(1, PAIR_A, 12'h801), frm(1, PAIR_B, 12'h7fe), 1, 0);
		reg_rd(ADDR_STATUS, rd);
		check("buffer drained", 0, rd[STAT_FULL]);
		// Four channels: address pin held low, input still alternates
		channel_count_select <= 1'b1;
		pair_address_select <= 1'b0;
		reg_wr(ADDR_CONV_LEN, 32'h12);
		reg_rd(ADDR_CONV_LEN, rd);
		check("conv_len", 32'h12, rd);
		repeat (2)
		begin
			prev_sel = input_select;
			convert(1, 18);
			check("input_select", {31'h0, ~prev_sel}, input_select);
		end
		// Four-channel words carry the alternating channel flag
		read_frames(16, frm(1, PAIR_A, 12'h801), frm(1, PAIR_B, 12'h7fe), 1, 0);
		code_a <= 12'h800;
		code_b <= 12'h7ff;
		read_frames(16, frm(0, PAIR_A, 12'h801), frm(0, PAIR_B, 12'h7fe), 1, 1);
		for (int i = 0; i < 1000 && hold_a !== 1'b0; i++)
			@(posedge ref_clk);
		check("input_select", 0, input_select);
		reg_rd(ADDR_RESULT_A, rd);
		check("result_a", 32'hfffff800, rd);
		reg_rd(ADDR_RESULT_B, rd);
		check("result_b", 32'h7ff, rd);
		give_verdict();
	end
endmodule : tb
